/* File: sim/iesv_top_tb.sv */
`timescale 1ns/100ps
module iesv_top_tb
  import iesv_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [IESV_DW-1:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [IESV_DW-1:0] hrdata;
  logic [IESV_NERR-1:0] err_event = '0;
  logic uncor_err;
  logic cor_err;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  // Posted timeouts, double-bit ECC, parity and replay double-bit set
  localparam logic [31:0] SEV_DEF = 32'h0004D511;
  localparam logic [31:0] IMPL = 32'h0007FFF7;

  always #5 ref_clk = ~ref_clk;

  iesv_top u_dut (
    .REF_CLK(ref_clk),
    .RST(rst),
    .HSEL(hsel),
    .HADDR(haddr),
    .HTRANS(htrans),
    .HWRITE(hwrite),
    .HSIZE(hsize),
    .HWDATA(hwdata),
    .HREADY(hreadyout),
    .HREADYOUT(hreadyout),
    .HRESP(hresp),
    .HRDATA(hrdata),
    .ERR_EVENT(err_event),
    .UNCOR_ERR(uncor_err),
    .COR_ERR(cor_err),
    .IRQ(irq)
  );

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic flags(input logic u, input logic c, input string what);
    chk({31'h0, uncor_err}, {31'h0, u}, what);
    chk({31'h0, cor_err}, {31'h0, c}, what);
    chk({31'h0, irq}, {31'h0, u | c}, what);
  endtask

  // Request held until hready is seen high, as a single-word master must
  task automatic bus(input logic wr, input logic [11:0] off, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, off};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rdv = hrdata;
    chk({31'h0, hresp}, 32'h0, "response");
    #1;
  endtask

  task automatic wr(input logic [11:0] off, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, off, d, dummy);
  endtask

  task automatic rdchk(input logic [11:0] off, input logic [31:0] exp, input string what);
    logic [31:0] v;
    bus(1'b0, off, 32'h0, v);
    chk(v, exp, what);
  endtask

  task automatic pulse(input int i);
    logic [IESV_NERR-1:0] ev;
    ev = '0;
    ev[i] = 1'b1;
    @(posedge ref_clk);
    err_event <= ev;
    @(posedge ref_clk);
    err_event <= '0;
    #1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] sev;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(IESV_SEV_OFF, SEV_DEF, "severity reset");
    rdchk(IESV_MSK_OFF, 32'h0, "mask reset");
    flags(1'b0, 1'b0, "idle flags");
    $display("test reset_values done");
    wr(IESV_SEV_OFF, 32'hFFFFFFFF);
    rdchk(IESV_SEV_OFF, IMPL, "reserved bits");
    wr(12'h400, 32'h0);
    rdchk(12'h400, 32'h0, "unmapped read");
    rdchk(IESV_SEV_OFF, IMPL, "unmapped write");
    pulse(IESV_B_RSVD);
    flags(1'b0, 1'b0, "reserved event");
    $display("test reserved done");
    // Both severity patterns so every implemented bit (bit 3 skipped) reports once each way
    for (int p = 0; p < 2; p++) begin
      sev = (p == 0) ? SEV_DEF : (~SEV_DEF & IMPL);
      wr(IESV_SEV_OFF, sev);
      for (int i = 0; i < IESV_NERR; i++) begin
        if (i != IESV_B_RSVD) begin
          pulse(i);
          flags(sev[i], ~sev[i], "class");
          rdchk(IESV_STS_OFF, 32'h1 << i, "status bit");
          flags(1'b0, 1'b0, "after clear");
        end
      end
    end
    $display("test classification done");
    wr(IESV_SEV_OFF, SEV_DEF);
    wr(IESV_MSK_OFF, 32'h00008000);
    rdchk(IESV_MSK_OFF, 32'h00008000, "mask write");
    pulse(IESV_B_DATAPATH_PARITY_ERR);
    flags(1'b0, 1'b0, "masked parity");
    wr(IESV_MSK_OFF, 32'h0);
    flags(1'b1, 1'b0, "unmasked parity");
    wr(IESV_SEV_OFF, 32'h0);
    flags(1'b0, 1'b1, "live downgrade");
    rdchk(IESV_STS_OFF, 32'h00008000, "status kept");
    $display("test mask done");
    tally_and_finish();
  end
endmodule // iesv_top_tb

/* File: verilog/iesv_ahb_slave.sv */
`timescale 1ns/100ps
module iesv_ahb_slave
  import iesv_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst, // Synchronous reset
  input wire logic hsel, // Slave select
  input wire logic [IESV_AW-1:0] haddr, // Low address bits
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [IESV_DW-1:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic [IESV_DW-1:0] rd_data, // Register read value
  output logic hreadyout, // Ready out, registered
  output logic hresp, // Response, always OKAY
  output logic [IESV_DW-1:0] hrdata, // Read data, registered
  output logic wr_en, // Write commit strobe
  output logic rd_en, // Read strobe
  output logic [IESV_AW-1:0] reg_addr, // Captured address
  output logic [IESV_DW-1:0] wr_data // Write data
);

  // ----------------------------------------------------------------
  // Transfer control
  // ----------------------------------------------------------------
  iesv_bus_state_t state_r, state_nxt;
  logic [IESV_AW-1:0] addr_r, addr_nxt;
  logic [IESV_DW-1:0] hrdata_r, hrdata_nxt;
  logic hready_r, hready_nxt;
  logic hresp_r;
  logic accept;

  assign accept = hsel && htrans[IESV_TRANS_ACT_BIT] && hready;

  // Reads take one wait state so a write in the previous data phase
  // has already landed before the read value is sampled.
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    hrdata_nxt = hrdata_r;
    hready_nxt = 1'b1;
    case (state_r)
      IESV_IDLE, IESV_WDATA: begin
        state_nxt = IESV_IDLE;
        if (accept) begin
          addr_nxt = haddr;
          if (hwrite) begin
            state_nxt = IESV_WDATA;
          end else begin
            state_nxt = IESV_RWAIT;
            hready_nxt = 1'b0;
          end
        end
      end
      IESV_RWAIT: begin
        hrdata_nxt = rd_data;
        state_nxt = IESV_IDLE;
      end
      default: begin
        state_nxt = IESV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= IESV_IDLE;
      addr_r <= '0;
      hrdata_r <= '0;
      hready_r <= 1'b1;
      hresp_r <= IESV_HRESP_OKAY;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      hrdata_r <= hrdata_nxt;
      hready_r <= hready_nxt;
      hresp_r <= IESV_HRESP_OKAY;
    end
  end

  assign wr_en = (state_r == IESV_WDATA);
  assign rd_en = (state_r == IESV_RWAIT);
  assign reg_addr = addr_r;
  assign wr_data = hwdata;
  assign hreadyout = hready_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;

endmodule // iesv_ahb_slave

/* File: verilog/iesv_pkg.sv */
package iesv_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int IESV_DW = 32;
  localparam int IESV_AW = 12;
  localparam logic [IESV_AW-1:0] IESV_STS_OFF = 12'h484;
  localparam logic [IESV_AW-1:0] IESV_MSK_OFF = 12'h488;
  localparam logic [IESV_AW-1:0] IESV_SEV_OFF = 12'h48C;
  localparam int IESV_TRANS_ACT_BIT = 1;
  localparam logic IESV_HRESP_OKAY = 1'b0;

  // ----------------------------------------------------------------
  // Field layout, one bit per internal error type
  // ----------------------------------------------------------------
  localparam int IESV_NERR = 19;
  localparam int IESV_B_INGRESS_POSTED_TIMEOUT = 0;
  localparam int IESV_B_INGRESS_NONPOSTED_TIMEOUT = 1;
  localparam int IESV_B_INGRESS_COMPLETION_TIMEOUT = 2;
  localparam int IESV_B_RSVD = 3;
  localparam int IESV_B_EGRESS_POSTED_TIMEOUT = 4;
  localparam int IESV_B_EGRESS_NONPOSTED_TIMEOUT = 5;
  localparam int IESV_B_EGRESS_COMPLETION_TIMEOUT = 6;
  localparam int IESV_B_ECC_FIRST = 7;
  localparam int IESV_B_ECC_LAST = 14;
  localparam int IESV_B_DATAPATH_PARITY_ERR = 15;
  localparam int IESV_B_UNRELIABLE_LINK_ERR = 16;
  localparam int IESV_B_REPLAY_CTL_SINGLE_ERR = 17;
  localparam int IESV_B_REPLAY_CTL_DOUBLE_ERR = 18;

  // ----------------------------------------------------------------
  // Reset values and implemented bits
  // ----------------------------------------------------------------
  localparam logic [IESV_DW-1:0] IESV_VALID_BITS = 32'h0007FFF7;
  localparam logic [IESV_DW-1:0] IESV_SEV_RST = 32'h0004D511;
  localparam logic [IESV_DW-1:0] IESV_MSK_RST = 32'h00000000;
  localparam logic [IESV_DW-1:0] IESV_STS_RST = 32'h00000000;
  localparam logic [7:0] IESV_ECC_SEV_RST = 8'hAA;

  typedef enum logic [1:0] {
    IESV_IDLE,
    IESV_WDATA,
    IESV_RWAIT
  } iesv_bus_state_t;

endpackage

/* File: verilog/iesv_top.sv */
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
// Behaviour
// [R1] An unmasked set error whose severity bit is one is reported as uncorrectable.
// [R2] An unmasked set error whose severity bit is zero is reported as correctable.
// [R3] Timeout severities sit at bits 0-2 and 4-6, posted resets to one, others to zero.
// [R4] Bits 7-14 are the buffer ECC severities, single-bit reset zero, double-bit reset one.
// [R5] Bit 15 is the datapath parity severity and resets to one.
// [R6] Bit 16 is the unreliable link severity and resets to zero.
// [R7] Bits 17 and 18 are the replay ECC severities, resetting to zero and one.
// [R8] A masked error is never reported, while its status bit is left untouched.
// [R9] Bit 3 and bits 19 to 31 read as zero and ignore writes.
module iesv_top
  import iesv_pkg::*;
(
  input wire logic REF_CLK, // Core clock, 100 MHz
  input wire logic RST, // Synchronous reset, high
  input wire logic HSEL, // AHB slave select
  input wire logic [31:0] HADDR, // AHB address
  input wire logic [1:0] HTRANS, // AHB transfer type
  input wire logic HWRITE, // AHB write
  input wire logic [2:0] HSIZE, // AHB size, word only
  input wire logic [IESV_DW-1:0] HWDATA, // AHB write data
  input wire logic HREADY, // AHB bus ready
  output logic HREADYOUT, // AHB ready out
  output logic HRESP, // AHB response
  output logic [IESV_DW-1:0] HRDATA, // AHB read data
  input wire logic [IESV_NERR-1:0] ERR_EVENT, // Error pulses, same clock
  output logic UNCOR_ERR, // Uncorrectable internal error
  output logic COR_ERR, // Correctable internal error
  output logic IRQ // Interrupt, level
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic [IESV_AW-1:0] reg_addr;
  logic [IESV_DW-1:0] wr_data;
  logic [IESV_DW-1:0] rd_data;

  iesv_ahb_slave u_slave (
    .clk(REF_CLK),
    .rst(RST),
    .hsel(HSEL),
    .haddr(HADDR[IESV_AW-1:0]),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .rd_data(rd_data),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .hrdata(HRDATA),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .reg_addr(reg_addr),
    .wr_data(wr_data)
  );

  // Upper address bits are not decoded, so the map aliases every 4 KB
  function automatic logic hits(input logic [IESV_AW-1:0] a, input logic [IESV_AW-1:0] off);
    hits = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [IESV_DW-1:0] sev_r, sev_nxt;
  logic [IESV_DW-1:0] msk_r, msk_nxt;
  logic [IESV_DW-1:0] sts_r, sts_nxt;
  logic [IESV_DW-1:0] evt_vec;
  logic sts_rd_clr;
  logic uncor_r, uncor_nxt;
  logic cor_r, cor_nxt;
  logic irq_r, irq_nxt;
  logic [IESV_DW-1:0] active;

  assign evt_vec = {{(IESV_DW-IESV_NERR){1'b0}}, ERR_EVENT} & IESV_VALID_BITS;
  assign sts_rd_clr = rd_en && hits(reg_addr, IESV_STS_OFF);

  // Severity and mask, whole-word writes; reserved bits stay zero
  always_comb begin
    sev_nxt = sev_r;
    msk_nxt = msk_r;
    if (wr_en && hits(reg_addr, IESV_SEV_OFF)) begin
      sev_nxt = wr_data & IESV_VALID_BITS; // R9
    end
    if (wr_en && hits(reg_addr, IESV_MSK_OFF)) begin
      msk_nxt = wr_data & IESV_VALID_BITS; // R9
    end
  end

  // Sticky status, one bit each; a new event beats a read clear
  genvar gi;
  generate
    for (gi = 0; gi < IESV_DW; gi++) begin : g_sts
      always_comb begin
        if (evt_vec[gi]) begin
          sts_nxt[gi] = 1'b1; // R8
        end else if (sts_rd_clr) begin
          sts_nxt[gi] = 1'b0;
        end else begin
          sts_nxt[gi] = sts_r[gi];
        end
      end
    end
  endgenerate

  // Mask gates reporting only, never the status bit
  always_comb begin
    active = sts_nxt & ~msk_nxt & IESV_VALID_BITS; // R8
    uncor_nxt = |(active & sev_nxt); // R1
    cor_nxt = |(active & ~sev_nxt); // R2
    irq_nxt = |active;
  end

  // Severity defaults also come back on RST; there is no separate
  // sticky-preserving reset in this block.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sev_r <= IESV_SEV_RST; // R3 R4 R5 R6 R7
      msk_r <= IESV_MSK_RST;
      sts_r <= IESV_STS_RST;
      uncor_r <= 1'b0;
      cor_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      sev_r <= sev_nxt;
      msk_r <= msk_nxt;
      sts_r <= sts_nxt;
      uncor_r <= uncor_nxt;
      cor_r <= cor_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    if (hits(reg_addr, IESV_SEV_OFF)) begin
      rd_data = sev_r & IESV_VALID_BITS; // R9
    end else if (hits(reg_addr, IESV_MSK_OFF)) begin
      rd_data = msk_r & IESV_VALID_BITS;
    end else if (hits(reg_addr, IESV_STS_OFF)) begin
      rd_data = sts_r & IESV_VALID_BITS;
    end
  end

  assign UNCOR_ERR = uncor_r;
  assign COR_ERR = cor_r;
  assign IRQ = irq_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [IESV_DW-1:0] act_r;
  assign act_r = sts_r & ~msk_r & IESV_VALID_BITS;

  a_uncor_report: assert property (@(posedge REF_CLK) disable iff (RST)
    UNCOR_ERR == |(act_r & sev_r)) // R1
    else $error("uncorrectable report disagrees with status and severity");

  a_cor_report: assert property (@(posedge REF_CLK) disable iff (RST)
    COR_ERR == |(act_r & ~sev_r)) // R2
    else $error("correctable report disagrees with status and severity");

  a_event_reports: assert property (@(posedge REF_CLK) disable iff (RST)
    (|(evt_vec & ~msk_nxt & sev_nxt)) |=> UNCOR_ERR) // R1
    else $error("unmasked uncorrectable event not reported next cycle");

  a_timeout_reset: assert property (@(posedge REF_CLK)
    $past(RST) |-> (sev_r[IESV_B_INGRESS_POSTED_TIMEOUT] &&
      !sev_r[IESV_B_INGRESS_NONPOSTED_TIMEOUT] &&
      !sev_r[IESV_B_INGRESS_COMPLETION_TIMEOUT] &&
      sev_r[IESV_B_EGRESS_POSTED_TIMEOUT] &&
      !sev_r[IESV_B_EGRESS_NONPOSTED_TIMEOUT] &&
      !sev_r[IESV_B_EGRESS_COMPLETION_TIMEOUT])) // R3
    else $error("timeout severity reset value wrong");

  a_ecc_reset: assert property (@(posedge REF_CLK)
    $past(RST) |-> sev_r[IESV_B_ECC_LAST:IESV_B_ECC_FIRST] == IESV_ECC_SEV_RST) // R4
    else $error("buffer ECC severity reset value wrong");

  a_parity_reset: assert property (@(posedge REF_CLK)
    $past(RST) |-> sev_r[IESV_B_DATAPATH_PARITY_ERR]) // R5
    else $error("parity severity not uncorrectable after reset");

  a_link_reset: assert property (@(posedge REF_CLK)
    $past(RST) |-> !sev_r[IESV_B_UNRELIABLE_LINK_ERR]) // R6
    else $error("link severity not correctable after reset");

  a_replay_reset: assert property (@(posedge REF_CLK)
    $past(RST) |-> (!sev_r[IESV_B_REPLAY_CTL_SINGLE_ERR] &&
      sev_r[IESV_B_REPLAY_CTL_DOUBLE_ERR])) // R7
    else $error("replay ECC severity reset value wrong");

  a_mask_blocks: assert property (@(posedge REF_CLK) disable iff (RST)
    ((sts_r & ~msk_r & IESV_VALID_BITS) == '0) |-> (!UNCOR_ERR && !COR_ERR)) // R8
    else $error("masked error was reported");

  a_mask_keeps_status: assert property (@(posedge REF_CLK) disable iff (RST)
    (|evt_vec) |=> ((sts_r & $past(evt_vec)) == $past(evt_vec))) // R8
    else $error("event did not set its status bit");

  a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (RST)
    ((sev_r | msk_r | sts_r | HRDATA) & ~IESV_VALID_BITS) == '0) // R9
    else $error("reserved bit became nonzero");

  a_sev_write: assert property (@(posedge REF_CLK) disable iff (RST)
    (wr_en && hits(reg_addr, IESV_SEV_OFF)) |=>
      (sev_r == ($past(wr_data) & IESV_VALID_BITS))) // R9
    else $error("severity write not stored");

  a_read_wait: assert property (@(posedge REF_CLK) disable iff (RST)
    (HSEL && HTRANS[IESV_TRANS_ACT_BIT] && HREADY && !HWRITE) |=>
      !HREADYOUT ##1 HREADYOUT)
    else $error("read did not take exactly one wait state");

  a_irq_level: assert property (@(posedge REF_CLK) disable iff (RST)
    IRQ == (UNCOR_ERR || COR_ERR))
    else $error("interrupt disagrees with error reports");

endmodule // iesv_top
